// >>> boot_mode_select_loader.sv
`timescale 1ns/1ns
`include "boot_map.svh"
// Contract
// - Mode taken from pins during reset
// - Boot pin high chip, low serial boot
// - Programmer under reset; others run after release
// - Boot pin pulled-up input during reset
// - After reset: chip drives, boot floats pulled
// - Chip mode sectors from FE0000H upward
// - Boot mode sectors 10000H to 2FFFFH
// - Boot ROM over vectors, start there
// - Wrong password refuses RAM transfer
// - Erased flash expects twelve 0xFF bytes
// - Built-in whole-chip erase command accepted
// - After load, jump to RAM entry
// - UART framing on serial channel one
module boot_mode_select_loader
	import boot_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic mode_pin_low,
	input wire logic mode_pin_high,
	input wire logic shared_boot_port_pin_in,
	output logic shared_boot_port_pin_out,
	output logic shared_boot_port_pin_oe,
	output logic shared_boot_port_pin_pullup,
	output logic shared_boot_port_pin_gate,
	input wire logic port_out_data,
	output logic cpu_run,
	output logic programmer_active,
	output logic single_boot,
	input wire addr_t cpu_addr,
	output logic flash_hit,
	output logic [`SECTOR_BITS-1:0] flash_sector,
	output logic [`SECTOR_OFS_BITS-1:0] flash_offset,
	output logic boot_rom_hit,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	input wire logic [8*`PW_BYTES-1:0] stored_password,
	input wire logic flash_erased,
	output logic pw_ok,
	output logic pw_fail,
	output logic load_err,
	output logic ram_we,
	output addr_t ram_addr,
	output logic [7:0] ram_data,
	input wire logic ram_ready,
	output logic chip_erase_req,
	input wire logic chip_erase_done,
	output logic exec_start,
	output addr_t exec_addr
);
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_filt;
	mode_e mode;
	mode_e next_mode;
	loader_e state;
	logic [15:0] cnt;
	addr_t ld_addr;
	addr_t entry;
	logic [15:0] ld_len;
	logic pw_bad;
	logic [24:0] load_last;
	logic [7:0] expect_byte;
	logic rx_fire;
	logic run_q;
	word_stream_if #(.WIDTH(32)) wr_in ();
	word_stream_if #(.WIDTH(32)) wr_out ();
	function automatic logic in_range(input addr_t a, input addr_t lo, input addr_t hi);
		return (a >= lo) && (a <= hi);
	endfunction
	// Empty routine or any byte outside the RAM window refuses the load
	function automatic logic window_bad(input addr_t a, input logic [15:0] n, input logic [24:0] last);
		return (n == 16'h0000) || (a < `RAM_LOAD_LO) || (last > {1'b0, `RAM_LOAD_HI});
	endfunction
	function automatic logic [`SECTOR_BITS-1:0] sector_of(input addr_t a, input addr_t base);
		addr_t d;
		d = a - base;
		return d[`SECTOR_OFS_BITS+`SECTOR_BITS-1:`SECTOR_OFS_BITS];
	endfunction
	// Pin synchroniser; runs through reset so pins settle while it is held
	always_ff @(posedge clk) begin
		pin_s1 <= {mode_pin_high, mode_pin_low, shared_boot_port_pin_in};
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end
	// A change counts once the last two stages agree
	always_ff @(posedge clk) begin
		if (pin_s2 == pin_s3) begin
			pin_filt <= pin_s3;
		end
	end
	// Mode decode from mode pins and boot pin
	assign next_mode = (pin_filt[2:1] != 2'b11) ? MODE_PROGRAMMER
		: (pin_filt[0] ? MODE_SINGLE_CHIP : MODE_SINGLE_BOOT);
	// Sampled only while reset is low, then frozen; later pin wiggles are ignored
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode <= next_mode;
		end
	end
	// Run status; programmer mode works only while reset stays low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			run_q <= 1'b0;
		end else begin
			run_q <= (mode != MODE_PROGRAMMER);
		end
	end
	assign cpu_run = run_q;
	assign programmer_active = !resetn && (mode == MODE_PROGRAMMER);
	assign single_boot = run_q && (mode == MODE_SINGLE_BOOT);
	// Boot pin direction: input with pull-up in reset, then per mode
	assign shared_boot_port_pin_oe = resetn && (mode == MODE_SINGLE_CHIP);
	assign shared_boot_port_pin_pullup = !shared_boot_port_pin_oe;
	assign shared_boot_port_pin_gate = !resetn;
	assign shared_boot_port_pin_out = shared_boot_port_pin_oe && port_out_data;
	// Address decode, registered one cycle behind the address
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flash_hit <= 1'b0;
			flash_sector <= '0;
			flash_offset <= '0;
			boot_rom_hit <= 1'b0;
		end else begin
			flash_offset <= cpu_addr[`SECTOR_OFS_BITS-1:0];
			flash_hit <= 1'b0;
			flash_sector <= '0;
			boot_rom_hit <= 1'b0;
			if (mode == MODE_SINGLE_CHIP && cpu_addr >= `FLASH_CHIP_BASE) begin
				flash_hit <= 1'b1;
				flash_sector <= sector_of(cpu_addr, `FLASH_CHIP_BASE);
			end else if (mode == MODE_SINGLE_BOOT) begin
				if (in_range(cpu_addr, `FLASH_BOOT_BASE, `FLASH_BOOT_LAST)) begin
					flash_hit <= 1'b1;
					flash_sector <= sector_of(cpu_addr, `FLASH_BOOT_BASE);
				end
				boot_rom_hit <= (cpu_addr >= `BOOT_ROM_BASE);
			end
		end
	end
	// Expected password byte, first byte in the top lane; erased flash reads all ones
	assign expect_byte = flash_erased ? `PW_ERASED_BYTE : stored_password[8*`PW_BYTES-1-8*cnt[3:0] -: 8];
	assign load_last = {1'b0, ld_addr} + {9'h000, ld_len} - 25'h0000001;
	assign rx_fire = rx_valid && rx_ready;
	// Loader only accepts bytes in receiving states; data waits on the buffer
	assign rx_ready = (state == S_DATA) ? wr_in.ready
		: (state inside {S_PW, S_CMD, S_ADDR, S_LEN, S_PW_FAIL});
	// Byte stream into the buffer toward RAM
	assign wr_in.valid = (state == S_DATA) && rx_valid;
	assign wr_in.data = {ld_addr, rx_data};
	// Loader sequence: boot ROM starts here after release in boot mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= S_IDLE;
			cnt <= 16'h0000;
			pw_bad <= 1'b0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (mode == MODE_SINGLE_BOOT) begin
						state <= S_PW;
					end
					cnt <= 16'h0000;
					pw_bad <= 1'b0;
				end
				S_PW: begin
					if (rx_fire) begin
						if (cnt == 16'(`PW_BYTES - 1)) begin
							cnt <= 16'h0000;
							state <= (pw_bad || rx_data != expect_byte) ? S_PW_FAIL : S_CMD;
						end else begin
							cnt <= cnt + 16'h0001;
							pw_bad <= pw_bad || (rx_data != expect_byte);
						end
					end
				end
				S_PW_FAIL: state <= S_PW_FAIL; // Bytes are swallowed; only a reset retries
				S_CMD: begin
					cnt <= 16'h0000;
					if (rx_fire && rx_data == `CMD_LOAD) begin
						state <= S_ADDR;
					end else if (rx_fire && rx_data == `CMD_ERASE) begin
						state <= S_ERASE;
					end
				end
				S_ADDR: begin
					if (rx_fire) begin
						cnt <= (cnt == 16'(`ADDR_BYTES - 1)) ? 16'h0000 : cnt + 16'h0001;
						if (cnt == 16'(`ADDR_BYTES - 1)) begin
							state <= S_LEN;
						end
					end
				end
				S_LEN: begin
					if (rx_fire) begin
						cnt <= (cnt == 16'(`LEN_BYTES - 1)) ? 16'h0000 : cnt + 16'h0001;
						if (cnt == 16'(`LEN_BYTES - 1)) begin
							state <= S_CHECK;
						end
					end
				end
				S_CHECK: begin
					// A routine outside the RAM window is refused before any write
					if (window_bad(ld_addr, ld_len, load_last)) begin
						state <= S_CMD;
					end else begin
						state <= S_DATA;
					end
				end
				S_DATA: begin
					if (rx_fire) begin
						cnt <= cnt + 16'h0001;
						if (cnt == ld_len - 16'h0001) begin
							state <= S_DRAIN;
						end
					end
				end
				S_DRAIN: begin
					if (!wr_out.valid) begin
						state <= S_JUMP;
					end
				end
				S_ERASE: begin
					if (chip_erase_done) begin
						state <= S_CMD;
					end
				end
				S_JUMP: state <= S_DONE;
				S_DONE: state <= S_DONE;
			endcase
		end
	end
	// Load address, length and entry capture; address steps per data byte
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ld_addr <= 24'h000000;
			ld_len <= 16'h0000;
			entry <= 24'h000000;
		end else if (rx_fire && state == S_ADDR) begin
			ld_addr <= {ld_addr[15:0], rx_data};
		end else if (rx_fire && state == S_LEN) begin
			ld_len <= {ld_len[7:0], rx_data};
		end else if (state == S_CHECK) begin
			entry <= ld_addr;
		end else if (rx_fire && state == S_DATA) begin
			ld_addr <= ld_addr + 24'h000001;
		end
	end
	// Status flags; a new load clears a stale range error
	always_ff @(posedge clk) begin
		if (!resetn) begin
			load_err <= 1'b0;
			exec_start <= 1'b0;
			exec_addr <= 24'h000000;
		end else begin
			exec_start <= (state == S_JUMP);
			if (state == S_JUMP) begin
				exec_addr <= entry;
			end
			if (state == S_CHECK) begin
				load_err <= window_bad(ld_addr, ld_len, load_last);
			end
		end
	end
	assign pw_fail = (state == S_PW_FAIL);
	assign pw_ok = (state != S_IDLE) && (state != S_PW) && (state != S_PW_FAIL);
	assign chip_erase_req = (state == S_ERASE);
	two_entry_buffer #(.WIDTH(32)) ram_buf (
		.clk(clk),
		.resetn(resetn),
		.fill(wr_in),
		.drain(wr_out)
	);
	// RAM write port straight from buffer flops
	assign ram_we = wr_out.valid;
	assign ram_addr = wr_out.data[31:8];
	assign ram_data = wr_out.data[7:0];
	assign wr_out.ready = ram_ready;
	sequence pw_last_byte;
		state == S_PW && rx_fire && cnt == 16'(`PW_BYTES - 1);
	endsequence

	sequence load_finished;
		state == S_DRAIN && !wr_out.valid;
	endsequence

	chk_mode_frozen: assert property (@(posedge clk) disable iff (!resetn) $stable(mode))
		else $error("mode changed outside reset");
	chk_pin_reset_cfg: assert property (@(posedge clk) !resetn |-> !shared_boot_port_pin_oe
		&& shared_boot_port_pin_pullup && shared_boot_port_pin_gate)
		else $error("boot pin not pulled input in reset");
	chk_pin_after_reset: assert property (@(posedge clk) disable iff (!resetn)
		shared_boot_port_pin_oe == (mode == MODE_SINGLE_CHIP) && !shared_boot_port_pin_gate
		&& shared_boot_port_pin_pullup == (mode != MODE_SINGLE_CHIP))
		else $error("boot pin direction wrong for mode");
	chk_chip_sector: assert property (@(posedge clk) disable iff (!resetn)
		mode == MODE_SINGLE_CHIP && cpu_addr >= 24'hFE0000 |=> flash_hit
		&& flash_sector == $past(cpu_addr[16:12]))
		else $error("single-chip sector decode wrong");
	chk_boot_sector: assert property (@(posedge clk) disable iff (!resetn)
		mode == MODE_SINGLE_BOOT |=> flash_hit == ($past(cpu_addr) >= 24'h010000 && $past(cpu_addr) <= 24'h02FFFF)
		&& boot_rom_hit == ($past(cpu_addr) >= 24'hFFF000))
		else $error("single-boot decode wrong");
	chk_pw_refuse: assert property (@(posedge clk) disable iff (!resetn)
		pw_last_byte and (##0 (pw_bad || rx_data != expect_byte)) |=> pw_fail [*4])
		else $error("bad password not refused");
	chk_erased_pw: assert property (@(posedge clk) disable iff (!resetn)
		pw_last_byte and (##0 (flash_erased && !pw_bad && rx_data == 8'hFF)) |=> state == S_CMD)
		else $error("erased password not accepted");
	chk_no_write_fail: assert property (@(posedge clk) disable iff (!resetn) pw_fail |-> !wr_in.valid && !ram_we)
		else $error("RAM write after refused password");
	chk_ram_window: assert property (@(posedge clk) disable iff (!resetn)
		ram_we |-> ram_addr >= 24'h001000 && ram_addr <= 24'h003DFF)
		else $error("RAM write outside load window");
	chk_jump_entry: assert property (@(posedge clk) disable iff (!resetn)
		load_finished |=> ##1 exec_start && exec_addr == entry ##1 !exec_start)
		else $error("jump to routine missing");
	chk_erase_cmd: assert property (@(posedge clk) disable iff (!resetn)
		state == S_CMD && rx_fire && rx_data == 8'h40 |=> chip_erase_req)
		else $error("erase command not issued");
	chk_programmer: assert property (@(posedge clk) programmer_active |-> !cpu_run ##1 (!resetn || !cpu_run))
		else $error("cpu running in programmer mode");
endmodule

// >>> boot_map.svh
`ifndef BOOT_MAP_SVH
`define BOOT_MAP_SVH

// Flash sector layout
`define SECTOR_COUNT 32
`define SECTOR_SIZE 24'h001000
`define SECTOR_BITS 5
`define SECTOR_OFS_BITS 12
`define FLASH_CHIP_BASE 24'hFE0000
`define FLASH_BOOT_BASE 24'h010000
`define FLASH_BOOT_LAST 24'h02FFFF

// Boot ROM window over the vector table
`define BOOT_ROM_BASE 24'hFFF000
`define BOOT_ROM_SIZE 24'h001000

// RAM window for the downloaded routine
`define RAM_LOAD_LO 24'h001000
`define RAM_LOAD_HI 24'h003DFF

// Password
`define PW_BYTES 12
`define PW_ERASED_BYTE 8'hFF

// Boot loader command bytes
`define CMD_LOAD 8'h30
`define CMD_ERASE 8'h40
`define ADDR_BYTES 3
`define LEN_BYTES 2

// Reset hold, in system clocks
`define RESET_HOLD_CLKS 10

`endif

// >>> boot_pkg.sv
package boot_pkg;
	typedef enum logic [1:0] {
		MODE_SINGLE_CHIP,
		MODE_SINGLE_BOOT,
		MODE_PROGRAMMER
	} mode_e;
	typedef enum logic [3:0] {
		S_IDLE,
		S_PW,
		S_PW_FAIL,
		S_CMD,
		S_ADDR,
		S_LEN,
		S_CHECK,
		S_DATA,
		S_DRAIN,
		S_ERASE,
		S_JUMP,
		S_DONE
	} loader_e;
	typedef logic [23:0] addr_t;
endpackage

// >>> word_stream_if.sv
`timescale 1ns/1ns
interface word_stream_if #(parameter int WIDTH = 32);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source(output valid, output data, input ready);
	modport sink(input valid, input data, output ready);
endinterface

// >>> two_entry_buffer.sv
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic resetn,
	word_stream_if.sink fill,
	word_stream_if.source drain
);
	logic [1:0] count;
	logic [WIDTH-1:0] head;
	logic [WIDTH-1:0] tail;
	logic push;
	logic pop;

	// Ready drops only when both entries hold words
	assign fill.ready = (count != 2'd2);
	assign drain.valid = (count != 2'd0);
	assign drain.data = head;
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	// Occupancy
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= 2'd0;
		end else if (push && !pop) begin
			count <= count + 2'd1;
		end else if (pop && !push) begin
			count <= count - 2'd1;
		end
	end

	// Entries; head always holds the oldest word
	always_ff @(posedge clk) begin
		if (!resetn) begin
			head <= '0;
			tail <= '0;
		end else if (pop) begin
			if (count == 2'd2) begin
				head <= tail;
			end else if (push) begin
				head <= fill.data;
			end
		end else if (push) begin
			if (count == 2'd0) begin
				head <= fill.data;
			end else begin
				tail <= fill.data;
			end
		end
	end
endmodule

// >>> prog_link_model.sv
`timescale 1ns/1ns
module prog_link_model (
	input wire logic clk,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	// Line idle at power-up
	initial begin
		rx_valid = 1'h0;
		rx_data = 8'hA5;
	end
	// One received UART byte, held until taken; gap models a slow sender
	task automatic put(input logic [7:0] b, input int gap, output logic ok);
		logic seen;
		ok = 1'h0;
		repeat (gap + 1) @(posedge clk); // Valid stays low across gap+1 edges between bytes
		#1 rx_valid = 1'h1;
		rx_data = b;
		for (int n = 0; n < 300 && !ok; n++) begin
			@(negedge clk) seen = rx_ready;
			@(posedge clk) ok = seen;
		end
		#1 rx_valid = 1'h0;
		rx_data = ~b; // Stale byte never looks valid
	endtask
endmodule

// >>> boot_mode_select_loader_tb.sv
`timescale 1ns/1ns
module boot_mode_select_loader_tb;
	import boot_pkg::*;
	typedef struct packed {
		logic [2:0] pins;
		addr_t addr;
		logic hit;
		logic [4:0] sec;
		logic rom;
		logic run;
		logic sb;
		logic oe;
	} row_s;
	logic clk = 1'h0, resetn = 1'h0, hi = 1'h1, lo = 1'h1, boot = 1'h1;
	logic pin_in, pin_out, pin_oe, pin_pu, pin_gate, cpu_run, prog, sb, hit, rom;
	addr_t addr = 24'h000000;
	logic [4:0] sec;
	logic [11:0] ofs;
	logic rx_valid, rx_ready, pw_ok, pw_fail, load_err, ram_we, erase_req, exec_start;
	logic [7:0] rx_data, ram_data;
	logic [95:0] stored_pw = 96'h0102030405060708090A0B0C;
	logic erased = 1'h0, ram_ready = 1'h1, erase_done = 1'h0, pod = 1'h1;
	addr_t ram_addr, exec_addr;
	logic [31:0] wq[$];
	logic [39:0] bad[3] = '{40'h000FFF0002, 40'h003DFF0002, 40'h0010000000};
	int execs = 0, err_total = 0, samples_checked = 0;
	row_s rows[9] = '{
		'{3'h7, 24'hFE3004, 1'h1, 5'h03, 1'h0, 1'h1, 1'h0, 1'h1},
		'{3'h7, 24'hFFFFFF, 1'h1, 5'h1F, 1'h0, 1'h1, 1'h0, 1'h1},
		'{3'h7, 24'h010000, 1'h0, 5'h00, 1'h0, 1'h1, 1'h0, 1'h1},
		'{3'h6, 24'h010000, 1'h1, 5'h00, 1'h0, 1'h1, 1'h1, 1'h0},
		'{3'h6, 24'h02FFFF, 1'h1, 5'h1F, 1'h0, 1'h1, 1'h1, 1'h0},
		'{3'h6, 24'h030000, 1'h0, 5'h00, 1'h0, 1'h1, 1'h1, 1'h0},
		'{3'h6, 24'hFFF000, 1'h0, 5'h00, 1'h1, 1'h1, 1'h1, 1'h0},
		'{3'h3, 24'hFE0000, 1'h0, 5'h00, 1'h0, 1'h0, 1'h0, 1'h0},
		'{3'h1, 24'hFFF000, 1'h0, 5'h00, 1'h0, 1'h0, 1'h0, 1'h0}};

	boot_mode_select_loader boot_mode_select_loader_i (.clk(clk), .resetn(resetn), .mode_pin_low(lo),
		.mode_pin_high(hi), .shared_boot_port_pin_in(pin_in), .shared_boot_port_pin_out(pin_out),
		.shared_boot_port_pin_oe(pin_oe), .shared_boot_port_pin_pullup(pin_pu),
		.shared_boot_port_pin_gate(pin_gate), .port_out_data(pod), .cpu_run(cpu_run),
		.programmer_active(prog), .single_boot(sb), .cpu_addr(addr), .flash_hit(hit), .flash_sector(sec),
		.flash_offset(ofs), .boot_rom_hit(rom), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.stored_password(stored_pw), .flash_erased(erased), .pw_ok(pw_ok), .pw_fail(pw_fail),
		.load_err(load_err), .ram_we(ram_we), .ram_addr(ram_addr), .ram_data(ram_data),
		.ram_ready(ram_ready), .chip_erase_req(erase_req), .chip_erase_done(erase_done),
		.exec_start(exec_start), .exec_addr(exec_addr));
	prog_link_model prog_link_model_i (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

	// Device drive wins; otherwise the external level
	assign pin_in = pin_oe ? pin_out : boot;
	always #20 clk = ~clk;
	// Sampled mid-cycle so the edge's own updates have settled
	always @(negedge clk) begin
		if (ram_we && ram_ready)
			wq.push_back({ram_addr, ram_data});
		if (exec_start)
			execs++;
	end

	task automatic wrap_up();
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_bit(input string what, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %b got %b", what, e, g);
		end
	endtask
	task automatic chk_val(input string what, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic send(input logic [7:0] b, input int gap);
		logic ok;
		prog_link_model_i.put(b, gap, ok);
		if (!ok) begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic load(input addr_t a, input logic [15:0] n);
		send(8'h30, 0);
		for (int k = 2; k >= 0; k--) send(a[8*k +: 8], 0);
		send(n[15:8], 1);
		send(n[7:0], 0);
	endtask
	task automatic do_reset(input logic [2:0] p);
		tick();
		resetn = 1'h0;
		{hi, lo, boot} = p;
		repeat (10) tick();
		chk_bit("gate in reset", 1'h1, pin_gate);
		chk_bit("pullup in reset", 1'h1, pin_pu);
		chk_bit("oe in reset", 1'h0, pin_oe);
		chk_bit("prog in reset", p[2:1] != 2'h3, prog);
		chk_bit("run in reset", 1'h0, cpu_run);
		resetn = 1'h1;
		tick();
		tick();
	endtask

	// Mode table, then loader sessions in serial boot mode
	initial begin
		foreach (rows[i]) begin
			pod = i[0]; // Port data alternates so the driven level is seen both ways
			do_reset(rows[i].pins);
			chk_bit("run", rows[i].run, cpu_run);
			chk_bit("single boot", rows[i].sb, sb);
			chk_bit("oe", rows[i].oe, pin_oe);
			chk_bit("pullup", !rows[i].oe, pin_pu);
			chk_bit("gate", 1'h0, pin_gate);
			chk_bit("pin out", rows[i].oe && i[0], pin_out);
			{hi, lo, boot} = ~rows[i].pins; // Late moves must not reach the mode
			addr = rows[i].addr;
			tick();
			chk_bit("flash hit", rows[i].hit, hit);
			chk_bit("rom hit", rows[i].rom, rom);
			if (rows[i].hit) begin
				chk_val("sector", {19'h0, rows[i].sec}, {19'h0, sec});
				chk_val("offset", {12'h0, rows[i].addr[11:0]}, {12'h0, ofs});
			end
			repeat (5) tick();
			chk_bit("mode held", rows[i].sb, sb);
		end
		do_reset(3'h6);
		for (int k = 0; k < 12; k++) send(k == 11 ? 8'hEE : 8'h01 + k[7:0], 0);
		tick();
		chk_bit("pw fail", 1'h1, pw_fail);
		chk_bit("pw ok", 1'h0, pw_ok);
		load(24'h001000, 16'h0001);
		send(8'h55, 0);
		repeat (4) tick();
		chk_val("writes after bad pw", 24'h0, 24'(wq.size()));
		do_reset(3'h6);
		erased = 1'h1;
		repeat (12) send(8'hFF, 0);
		tick();
		chk_bit("pw ok", 1'h1, pw_ok);
		send(8'h40, 0);
		repeat (3) tick();
		chk_bit("erase req", 1'h1, erase_req);
		erase_done = 1'h1;
		tick();
		erase_done = 1'h0;
		chk_bit("erase req end", 1'h0, erase_req);
		foreach (bad[i]) begin
			load(bad[i][39:16], bad[i][15:0]);
			repeat (3) tick();
			chk_bit("load err", 1'h1, load_err);
		end
		chk_val("writes refused", 24'h0, 24'(wq.size()));
		// RAM stalls so the buffer fills and the link must wait
		ram_ready = 1'h0;
		load(24'h003DFC, 16'h0004);
		fork
			for (int k = 0; k < 4; k++) send(8'hD0 + k[7:0], 0);
			begin
				repeat (8) tick();
				chk_bit("rx stalled", 1'h0, rx_ready);
				ram_ready = 1'h1;
			end
		join
		for (int n = 0; n < 50 && execs == 0; n++) tick(); // Completion polled, no interrupt
		tick();
		chk_val("exec count", 24'h1, 24'(execs));
		chk_val("exec addr", 24'h003DFC, exec_addr);
		chk_bit("rx closed", 1'h0, rx_ready);
		chk_val("write count", 24'h4, 24'(wq.size()));
		for (int k = 0; k < 4; k++) begin
			chk_val("ram addr", 24'h003DFC + k[23:0], wq[k][31:8]);
			chk_val("ram data", {16'h0, 8'hD0 + k[7:0]}, {16'h0, wq[k][7:0]});
		end
		chk_bit("load ok", 1'h0, load_err);
		wrap_up();
	end
endmodule
